// >>> rtl/smc_pkg.sv
/*
 Package for the serial menu configuration interpreter: register map,
 field layouts, reset values, character codes, timing counts, state types.
 Assumes a 10 MHz module clock and a 32-bit APB register bus.
*/
package smc_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_RX = 12'h000;
	localparam logic [11:0] OFF_TX = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_OUT1 = 12'h00C;
	localparam logic [11:0] OFF_OUT2 = 12'h010;
	localparam logic [11:0] OFF_BAL = 12'h014;
	localparam logic [11:0] OFF_SER = 12'h018;
	localparam logic [11:0] OFF_DISP = 12'h01C;
	localparam logic [11:0] OFF_AVG = 12'h020;
	localparam logic [11:0] OFF_QUERY = 12'h024;
	// Character codes
	localparam logic [7:0] CH_ESC = 8'h1B;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_D = 8'h44;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	// Access code word, six characters, first in the top byte
	localparam logic [47:0] ACCESS_WORD = 48'h41_43_43_45_53_53;
	// Unit set bits: dew C, dew F, RH, temp C, temp F
	localparam logic [4:0] UNITS_ALL = 5'h1F;
	localparam logic [4:0] SER_UNITS_RST = 5'h03;
	// Balance defaults: periodic heat-clean type, 0 days 12 hours
	localparam logic [7:0] BAL_DAYS_RST = 8'h00;
	localparam logic [4:0] BAL_HOURS_RST = 5'h0C;
	localparam logic [4:0] HOURS_MAX = 5'h17;
	localparam logic [4:0] AVG_RST = 5'h14;
	localparam logic [4:0] AVG_MAX = 5'h14;
	// Access levels
	localparam logic [1:0] ACC_VIEW = 2'h0;
	localparam logic [1:0] ACC_CHANGE = 2'h1;
	localparam logic [1:0] ACC_HIDE = 2'h2;
	// Alternate display period
	localparam int ALT_PERIOD_MS = 2000;
	localparam int CLK_HZ = 10_000_000;
	localparam int ALT_CYCLES = ALT_PERIOD_MS * (CLK_HZ / 1000);

	typedef enum logic [13:0] {
		ST_OPER = 14'h0001,
		ST_ESC1 = 14'h0002,
		ST_MAIN = 14'h0004,
		ST_SCALE = 14'h0008,
		ST_OPAR = 14'h0010,
		ST_NUM = 14'h0020,
		ST_BAL = 14'h0040,
		ST_SER = 14'h0080,
		ST_SUNITS = 14'h0100,
		ST_CODE = 14'h0200,
		ST_DISP = 14'h0400,
		ST_DUNITS = 14'h0800,
		ST_AVG = 14'h1000,
		ST_QRY = 14'h2000
	} smc_state_t;

	// What the numeric entry is filling in
	typedef enum logic [2:0] {
		NF_HIGH = 3'h0,
		NF_LOW = 3'h1,
		NF_DAYS = 3'h2,
		NF_HOURS = 3'h3,
		NF_AVG = 3'h4
	} smc_numf_t;

	typedef struct packed {
		logic [3:0] param;
		logic signed [15:0] high;
		logic signed [15:0] low;
	} smc_out_t;

	typedef struct packed {
		logic auto_type;
		logic [7:0] days;
		logic [4:0] hours;
	} smc_bal_t;

	typedef struct packed {
		smc_state_t st;
		smc_numf_t nf;
		logic outsel;
		logic neg;
		logic signed [15:0] acc;
		logic signed [15:0] hold;
		logic [3:0] pend_param;
		logic [47:0] code;
		logic [1:0] dsub;
		smc_out_t out1;
		smc_out_t out2;
		smc_bal_t bal;
		logic [4:0] ser_units;
		logic query_en;
		logic hs_en;
		logic [4:0] disp_units;
		logic alt_mode;
		logic [1:0] out_access;
		logic [1:0] alarm_access;
		logic [4:0] avg_n;
		logic bal_req;
		logic bal_remote;
		logic [1:0] query_sel;
		logic query_stb;
		logic [7:0] echo;
		logic echo_stb;
		logic [24:0] alt_cnt;
		logic [2:0] alt_idx;
	} smc_state_all_t;
endpackage

// >>> rtl/smc_interp.sv
/*
 Serial menu configuration interpreter. Characters from the terminal
 receiver arrive as rx_valid/rx_char; each accepted menu key or setting, except
 access code characters, is echoed on the echo outputs for the transmitter. Settings are visible
 over APB, except that only bit 0 of the output one parameter is readable. Assumes an external UART and a synchronous, active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Two consecutive escapes enter the main menu
// - No menu entry while balance runs
// - Menu active disables cooler, blanks display
// - Exit key leaves menu, restores operation
// - Key one opens scaling, echoes the key
// - Output one parameter, high, low entry
// - Output two offers only temperature units
// - Balance type select, heat-clean default
// - Balance interval entered as days, hours
// - Key four starts balance, then operate
// - Serial units added per key, six clears
// - Query mode answers D1, D2, D3
// - Handshake toggles only after access code
// - Display units added per key, six clears
// - Fixed or alternate display every two seconds
// - Output access level, hidden still applies
// - Alarm access level with same choices
// - Average depth one to twenty, default twenty
module smc_interp (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Terminal character stream
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	output logic [7:0] echo_char,
	output logic echo_valid,
	// Instrument side
	input wire logic balance_busy,
	output logic cooler_enable,
	output logic display_blank,
	output logic balance_start,
	output logic [2:0] display_unit,
	output logic periodic_out_en,
	output logic [1:0] query_unit,
	output logic query_valid
);
	smc_pkg::smc_state_all_t s_r, s_nxt;
	logic [7:0] ch;
	logic is_dig, menu_on, apb_wr;
	logic [3:0] dig;
	logic signed [15:0] num_val;
	logic [31:0] rd_mux;
	logic rd_err;

	assign ch = rx_char;
	assign is_dig = (ch >= smc_pkg::CH_0) && (ch <= smc_pkg::CH_9);
	assign dig = ch[3:0];
	assign num_val = s_r.neg ? -s_r.acc : s_r.acc;
	// cooler off and display blank in menu
	assign menu_on = !(s_r.st inside {smc_pkg::ST_OPER, smc_pkg::ST_ESC1, smc_pkg::ST_QRY});
	assign apb_wr = psel && penable && pwrite;

	// Interpreter next state; characters are consumed one per rx_valid
	always_comb begin
		s_nxt = s_r;
		s_nxt.echo_stb = 1'b0;
		s_nxt.query_stb = 1'b0;
		s_nxt.bal_req = 1'b0;
		// remote balance flag clears once balance_busy is low after the start pulse
		if (s_r.bal_remote && !balance_busy && !s_r.bal_req) begin
			s_nxt.bal_remote = 1'b0;
		end
		// alternate display steps every two seconds
		if (s_r.alt_mode && s_r.disp_units != 5'h00) begin
			// Two seconds of module clock need 25 bits; 24 would wrap early
			if (s_r.alt_cnt == 25'(smc_pkg::ALT_CYCLES - 1)) begin
				s_nxt.alt_cnt = 25'h0000000;
				s_nxt.alt_idx = (s_r.alt_idx == 3'h4) ? 3'h0 : s_r.alt_idx + 3'h1;
			end else begin
				s_nxt.alt_cnt = s_r.alt_cnt + 25'h0000001;
			end
		end else begin
			s_nxt.alt_cnt = 25'h0000000;
		end
		if (rx_valid) begin
			s_nxt.echo = ch;
			unique case (s_r.st)
				smc_pkg::ST_OPER, smc_pkg::ST_QRY: begin
					if (s_r.st == smc_pkg::ST_QRY) begin
						s_nxt.st = smc_pkg::ST_OPER;
						if (ch == smc_pkg::CH_CR && s_r.query_sel != 2'h0) begin
							s_nxt.query_stb = 1'b1;
						end
					end else if (ch == smc_pkg::CH_ESC) begin
						s_nxt.st = smc_pkg::ST_ESC1;
					end else if (s_r.query_en && ch == smc_pkg::CH_D) begin
						s_nxt.query_sel = 2'h0;
					end else if (s_r.query_en && s_r.echo == smc_pkg::CH_D &&
						ch >= 8'h31 && ch <= 8'h33) begin
						s_nxt.query_sel = ch[1:0];
						s_nxt.st = smc_pkg::ST_QRY;
					end
				end
				smc_pkg::ST_ESC1: begin
					// refused while a balance cycle runs
					if (ch == smc_pkg::CH_ESC && !balance_busy && !s_r.bal_remote) begin
						s_nxt.st = smc_pkg::ST_MAIN;
						s_nxt.echo_stb = 1'b1;
					end else begin
						s_nxt.st = smc_pkg::ST_OPER;
					end
				end
				smc_pkg::ST_MAIN: begin
					s_nxt.echo_stb = 1'b1;
					unique case (ch)
						smc_pkg::CH_E: s_nxt.st = smc_pkg::ST_OPER;
						8'h31: s_nxt.st = smc_pkg::ST_SCALE;
						8'h32: s_nxt.st = smc_pkg::ST_BAL;
						8'h33: s_nxt.st = smc_pkg::ST_SER;
						8'h34: s_nxt.st = smc_pkg::ST_DISP;
						8'h35: s_nxt.st = smc_pkg::ST_AVG;
						default: s_nxt.echo_stb = 1'b0;
					endcase
				end
				smc_pkg::ST_SCALE: begin
					if (ch == smc_pkg::CH_E) begin
						s_nxt.st = smc_pkg::ST_MAIN;
					end else if (ch == 8'h31 || ch == 8'h32) begin
						s_nxt.outsel = ch[1];
						s_nxt.st = smc_pkg::ST_OPAR;
					end
					s_nxt.echo_stb = (s_nxt.st != s_r.st);
				end
				smc_pkg::ST_OPAR: begin
					// output one: 0 dew C, 1 dew F, 2 RH
					// output two: 0 temp C, 1 temp F
					if (ch == smc_pkg::CH_E) begin
						s_nxt.st = smc_pkg::ST_SCALE;
						s_nxt.echo_stb = 1'b1;
					end else if ((!s_r.outsel && ch >= 8'h30 && ch <= 8'h32) ||
						(s_r.outsel && ch >= 8'h30 && ch <= 8'h31)) begin
						s_nxt.pend_param = s_r.outsel ? dig + 4'h3 : dig;
						s_nxt.nf = smc_pkg::NF_HIGH;
						s_nxt.acc = 16'sh0000;
						s_nxt.neg = 1'b0;
						s_nxt.st = smc_pkg::ST_NUM;
						s_nxt.echo_stb = 1'b1;
					end
				end
				smc_pkg::ST_NUM: begin
					// Numeric entry with optional leading minus
					s_nxt.echo_stb = 1'b1;
					if (is_dig) begin
						s_nxt.acc = 16'(s_r.acc * 16'sd10 + $signed({12'h000, dig}));
					end else if (ch == 8'h2D && s_r.acc == 16'sh0000) begin
						s_nxt.neg = 1'b1;
					end else if (ch == smc_pkg::CH_CR) begin
						s_nxt.acc = 16'sh0000;
						s_nxt.neg = 1'b0;
						unique case (s_r.nf)
							smc_pkg::NF_HIGH: begin
								s_nxt.hold = num_val;
								s_nxt.nf = smc_pkg::NF_LOW;
							end
							smc_pkg::NF_LOW: begin
								if (s_r.outsel) begin
									s_nxt.out2 = '{s_r.pend_param, s_r.hold, num_val};
								end else begin
									s_nxt.out1 = '{s_r.pend_param, s_r.hold, num_val};
								end
								s_nxt.st = smc_pkg::ST_SCALE;
							end
							smc_pkg::NF_DAYS: begin
								s_nxt.hold = num_val;
								s_nxt.nf = smc_pkg::NF_HOURS;
							end
							smc_pkg::NF_HOURS: begin
								if (num_val >= 0 && num_val <= $signed({11'h000, smc_pkg::HOURS_MAX})
									&& s_r.hold >= 0 && s_r.hold < 16'sd256) begin
									s_nxt.bal.days = s_r.hold[7:0];
									s_nxt.bal.hours = num_val[4:0];
								end
								s_nxt.st = smc_pkg::ST_BAL;
							end
							default: begin
								if (num_val >= 16'sd1 && num_val <= $signed({11'h000, smc_pkg::AVG_MAX})) begin
									s_nxt.avg_n = num_val[4:0];
								end
								s_nxt.st = smc_pkg::ST_AVG;
							end
						endcase
					end else begin
						s_nxt.echo_stb = 1'b0;
					end
				end
				smc_pkg::ST_BAL: begin
					s_nxt.echo_stb = 1'b1;
					unique case (ch)
						8'h31: s_nxt.bal.auto_type = 1'b0;
						8'h32: s_nxt.bal.auto_type = 1'b1;
						8'h33: begin
							s_nxt.nf = smc_pkg::NF_DAYS;
							s_nxt.acc = 16'sh0000;
							s_nxt.neg = 1'b0;
							s_nxt.st = smc_pkg::ST_NUM;
						end
						8'h34: begin
							s_nxt.bal_req = 1'b1;
							s_nxt.bal_remote = 1'b1;
							s_nxt.st = smc_pkg::ST_OPER;
						end
						smc_pkg::CH_E: s_nxt.st = smc_pkg::ST_MAIN;
						default: s_nxt.echo_stb = 1'b0;
					endcase
				end
				smc_pkg::ST_SER: begin
					s_nxt.echo_stb = 1'b1;
					unique case (ch)
						8'h31: s_nxt.st = smc_pkg::ST_SUNITS;
						8'h32: begin
							s_nxt.code = 48'h0;
							s_nxt.st = smc_pkg::ST_CODE;
						end
						// Query mode on and off share this level
						8'h51: s_nxt.query_en = 1'b1;
						8'h50: s_nxt.query_en = 1'b0;
						8'h33, smc_pkg::CH_E: s_nxt.st = smc_pkg::ST_MAIN;
						default: s_nxt.echo_stb = 1'b0;
					endcase
				end
				smc_pkg::ST_SUNITS, smc_pkg::ST_DUNITS: begin
					s_nxt.echo_stb = 1'b1;
					if (ch == smc_pkg::CH_E) begin
						s_nxt.st = (s_r.st == smc_pkg::ST_SUNITS) ? smc_pkg::ST_SER
							: smc_pkg::ST_DISP;
					end else if (ch >= 8'h31 && ch <= 8'h36) begin
						if (s_r.st == smc_pkg::ST_SUNITS) begin
							s_nxt.ser_units = (ch == 8'h36) ? 5'h00
								: s_r.ser_units | 5'(5'h01 << (dig - 4'h1));
						end else begin
							s_nxt.disp_units = (ch == 8'h36) ? 5'h00
								: s_r.disp_units | 5'(5'h01 << (dig - 4'h1));
						end
					end else begin
						s_nxt.echo_stb = 1'b0;
					end
				end
				smc_pkg::ST_CODE: begin
					// toggle only on exact code then return
					if (ch == smc_pkg::CH_CR) begin
						if (s_r.code == smc_pkg::ACCESS_WORD) begin
							s_nxt.hs_en = !s_r.hs_en;
							s_nxt.echo_stb = 1'b1;
						end
						s_nxt.st = smc_pkg::ST_SER;
					end else begin
						s_nxt.code = {s_r.code[39:0], ch};
					end
				end
				smc_pkg::ST_DISP: begin
					// dsub: 0 top, 1 outputs access, 2 alarm access, 3 fix/alt
					s_nxt.echo_stb = 1'b1;
					if (ch == smc_pkg::CH_E) begin
						if (s_r.dsub == 2'h0) begin
							s_nxt.st = smc_pkg::ST_MAIN;
						end else begin
							s_nxt.dsub = 2'h0;
						end
					end else if (s_r.dsub == 2'h0 && ch == 8'h31) begin
						s_nxt.st = smc_pkg::ST_DUNITS;
					end else if (s_r.dsub == 2'h0 && (ch == 8'h32 || ch == 8'h33 || ch == 8'h46)) begin
						s_nxt.dsub = (ch == 8'h46) ? 2'h3 : ch[1:0] - 2'h1;
					end else if (s_r.dsub == 2'h3 && (ch == 8'h31 || ch == 8'h32)) begin
						s_nxt.alt_mode = ch[1];
					end else if (s_r.dsub != 2'h0 && s_r.dsub != 2'h3 && ch >= 8'h31 && ch <= 8'h33) begin
						if (s_r.dsub == 2'h1) begin
							s_nxt.out_access = ch[1:0] - 2'h1;
						end else begin
							s_nxt.alarm_access = ch[1:0] - 2'h1;
						end
					end else begin
						s_nxt.echo_stb = 1'b0;
					end
				end
				smc_pkg::ST_AVG: begin
					s_nxt.echo_stb = 1'b1;
					if (ch == 8'h31) begin
						s_nxt.nf = smc_pkg::NF_AVG;
						s_nxt.acc = 16'sh0000;
						s_nxt.neg = 1'b0;
						s_nxt.st = smc_pkg::ST_NUM;
					end else if (ch == smc_pkg::CH_E) begin
						s_nxt.st = smc_pkg::ST_MAIN;
					end else begin
						s_nxt.echo_stb = 1'b0;
					end
				end
				default: s_nxt.st = smc_pkg::ST_OPER;
			endcase
		end
		// Software writes to the averaging register follow the same limit
		if (apb_wr && paddr == smc_pkg::OFF_AVG && pwdata[4:0] >= 5'h01
			&& pwdata[4:0] <= smc_pkg::AVG_MAX && pwdata[31:5] == 27'h0) begin
			s_nxt.avg_n = pwdata[4:0];
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.st <= smc_pkg::ST_OPER;
			s_r.out1 <= '{4'h0, 16'sd60, -16'sd40};
			s_r.out2 <= '{4'h3, 16'sd60, -16'sd40};
			s_r.bal <= '{1'b0, smc_pkg::BAL_DAYS_RST, smc_pkg::BAL_HOURS_RST};
			s_r.ser_units <= smc_pkg::SER_UNITS_RST;
			s_r.disp_units <= smc_pkg::UNITS_ALL;
			s_r.out_access <= smc_pkg::ACC_VIEW;
			s_r.alarm_access <= smc_pkg::ACC_VIEW;
			s_r.avg_n <= smc_pkg::AVG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// APB read mux; one wait-free access, unmapped address flags an error
	always_comb begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		unique case (paddr)
			smc_pkg::OFF_RX: rd_mux = {24'h000000, s_r.echo};
			smc_pkg::OFF_TX: rd_mux = {18'h00000, s_r.st};
			smc_pkg::OFF_STATUS: rd_mux = {28'h0000000, s_r.bal_remote, balance_busy, menu_on, s_r.hs_en};
			smc_pkg::OFF_OUT1: rd_mux = {s_r.out1.high, s_r.out1.low};
			smc_pkg::OFF_OUT2: rd_mux = {s_r.out2.high, s_r.out2.low};
			smc_pkg::OFF_BAL: rd_mux = {18'h00000, s_r.bal};
			smc_pkg::OFF_SER: rd_mux = {22'h000000, s_r.out2.param, s_r.out1.param[0], s_r.ser_units};
			smc_pkg::OFF_DISP: rd_mux = {22'h000000, s_r.alt_mode, s_r.alarm_access, s_r.out_access, s_r.disp_units};
			smc_pkg::OFF_AVG: rd_mux = {27'h0000000, s_r.avg_n};
			smc_pkg::OFF_QUERY: rd_mux = {29'h00000000, s_r.query_en, s_r.query_sel};
			default: rd_err = 1'b1;
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && rd_err;
	assign prdata = (psel && !pwrite) ? rd_mux : 32'h00000000;

	// Instrument-facing outputs
	assign cooler_enable = !menu_on;
	assign display_blank = menu_on;
	assign balance_start = s_r.bal_req;
	assign display_unit = s_r.alt_mode ? s_r.alt_idx : 3'h0;
	assign periodic_out_en = !s_r.query_en && s_r.ser_units != 5'h00;
	assign query_unit = s_r.query_sel;
	assign query_valid = s_r.query_stb;
	assign echo_char = s_r.echo;
	assign echo_valid = s_r.echo_stb;

	// a_menu_blank: main menu state always blanks display and stops cooler
	a_menu_blank: assert property (@(posedge ref_clk) disable iff (reset)
		s_r.st == smc_pkg::ST_MAIN |-> display_blank && !cooler_enable)
		else $error("menu active but cooler or display not suppressed");
	a_double_esc: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(s_r.st == smc_pkg::ST_MAIN) && $past(s_r.st) == smc_pkg::ST_ESC1
		|-> $past(rx_char) == smc_pkg::CH_ESC)
		else $error("main menu entered without second escape");
	a_bal_refuse: assert property (@(posedge ref_clk) disable iff (reset)
		s_r.st == smc_pkg::ST_ESC1 && rx_valid && balance_busy |=> s_r.st == smc_pkg::ST_OPER)
		else $error("menu entered during balance");
	a_exit_oper: assert property (@(posedge ref_clk) disable iff (reset)
		s_r.st == smc_pkg::ST_MAIN && rx_valid && rx_char == smc_pkg::CH_E
		|=> cooler_enable && !display_blank)
		else $error("exit key did not restore operation");
	a_bal_start: assert property (@(posedge ref_clk) disable iff (reset)
		s_r.st == smc_pkg::ST_BAL && rx_valid && rx_char == 8'h34
		|=> balance_start && s_r.st == smc_pkg::ST_OPER ##1 !balance_start)
		else $error("remote balance start wrong");
	a_avg_range: assert property (@(posedge ref_clk) disable iff (reset)
		s_r.avg_n >= 5'h01 && s_r.avg_n <= smc_pkg::AVG_MAX)
		else $error("averaging depth out of range");
	a_code_gate: assert property (@(posedge ref_clk) disable iff (reset)
		s_r.hs_en != $past(s_r.hs_en) |-> $past(s_r.code) == smc_pkg::ACCESS_WORD)
		else $error("handshake toggled without access code");
	a_query_only: assert property (@(posedge ref_clk) disable iff (reset)
		query_valid |-> !periodic_out_en && query_unit != 2'h0)
		else $error("query answered outside query mode");
	a_unit_clear: assert property (@(posedge ref_clk) disable iff (reset)
		s_r.st == smc_pkg::ST_SUNITS && rx_valid && rx_char == 8'h36 |=> s_r.ser_units == 5'h00)
		else $error("key six did not clear serial units");
endmodule

`default_nettype wire

// >>> tb/smc_term.sv
/*
 Operator terminal model: sends keystrokes to the interpreter one at a time.
 Assumes the interpreter takes a character at any edge where rx_valid is high.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_term (
	// Clock
	input wire logic ref_clk,
	// Character stream toward the interpreter
	output logic rx_valid,
	output logic [7:0] rx_char
);
	// Quiet line at time zero
	initial begin
		rx_valid = 1'b0;
		rx_char = 8'h00;
	end
	// One character for one edge; afterwards the data lines show its inverse,
	// so a design that samples without the strobe sees garbage, not the key
	task automatic send_char(input logic [7:0] c);
		@(posedge ref_clk);
		rx_valid <= 1'b1;
		rx_char <= c;
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		rx_char <= ~c;
	endtask
	// Whole string, first character first
	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) begin
			send_char(8'(s[i]));
		end
	endtask
	task automatic enter_menu();
		send_char(smc_pkg::CH_ESC);
		send_char(smc_pkg::CH_ESC);
	endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
/*
 Self-checking bench for the menu interpreter: terminal keystrokes through
 the terminal model, register access over APB, instrument outputs watched.
 Assumes the design's zero-wait APB slave and one-cycle output pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic ref_clk, reset, psel, penable, pwrite, balance_busy, rx_valid, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, echo_valid, cooler_enable, display_blank;
	logic balance_start, periodic_out_en, query_valid;
	logic [7:0] rx_char, echo_char;
	logic [2:0] display_unit;
	logic [1:0] query_unit, q_unit;
	int bad_count, samples_checked, echo_cnt, bal_cnt, q_cnt, e0;

	smc_interp DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_char(rx_char), .echo_char(echo_char),
		.echo_valid(echo_valid), .balance_busy(balance_busy), .cooler_enable(cooler_enable),
		.display_blank(display_blank), .balance_start(balance_start),
		.display_unit(display_unit), .periodic_out_en(periodic_out_en),
		.query_unit(query_unit), .query_valid(query_valid));
	smc_term TERM (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_char(rx_char));

	// Clock, 100 ns period
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	// Pulse counters; pulses stand one cycle, so every edge is looked at
	always @(posedge ref_clk) begin
		if (echo_valid === 1'b1) echo_cnt++;
		if (balance_start === 1'b1) bal_cnt++;
		if (query_valid === 1'b1) begin
			q_cnt++;
			q_unit = query_unit;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("Checked %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			$display("BAD %0t no pready", $time);
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Let a taken key settle, then check menu or operate state
	task automatic chk_mode(input logic menu);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, display_blank}, {31'h0, menu}, "display blank");
		chk({31'h0, cooler_enable}, {31'h0, !menu}, "cooler enable");
	endtask

	task automatic sc_entry();
		TERM.send_str("\033x");
		chk_mode(1'b0);
		TERM.enter_menu();
		chk_mode(1'b1);
		e0 = echo_cnt;
		TERM.send_str("Z");
		chk_mode(1'b1);
		chk(echo_cnt, e0, "echo on bad key");
		TERM.send_str("E");
		chk_mode(1'b0);
		chk({24'h0, echo_char}, {24'h0, smc_pkg::CH_E}, "echo of exit key");
		balance_busy <= 1'b1;
		TERM.enter_menu();
		chk_mode(1'b0);
		balance_busy <= 1'b0;
	endtask

	task automatic sc_avg();
		TERM.enter_menu();
		TERM.send_str("51");
		repeat (3) @(posedge ref_clk);
		e0 = echo_cnt;
		TERM.send_str("7\015");
		repeat (3) @(posedge ref_clk);
		chk({31'h0, echo_cnt > e0}, 32'h1, "setting echo");
		apb(1'b0, smc_pkg::OFF_AVG, 32'h0);
		chk(rd, 32'h7, "avg by menu");
		TERM.send_str("125\015EE");
		chk_mode(1'b0);
		apb(1'b0, smc_pkg::OFF_AVG, 32'h0);
		chk(rd, 32'h7, "avg out of range");
		apb(1'b1, smc_pkg::OFF_AVG, 32'h15);
		apb(1'b0, smc_pkg::OFF_AVG, 32'h0);
		chk(rd, 32'h7, "avg write 21");
		apb(1'b1, smc_pkg::OFF_AVG, 32'h1);
		apb(1'b0, smc_pkg::OFF_AVG, 32'h0);
		chk(rd, 32'h1, "avg write 1");
		apb(1'b0, 12'h040, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped slave error");
	endtask

	task automatic sc_balance();
		TERM.enter_menu();
		TERM.send_str("24");
		chk_mode(1'b0);
		chk(bal_cnt, 1, "balance start pulses");
	endtask

	// Output scaling, then balance type and interval through the menu
	task automatic sc_scale_bal();
		TERM.enter_menu();
		TERM.send_str("11295\015-5\015");
		TERM.send_str("231100\0150\015E");
		apb(1'b0, smc_pkg::OFF_OUT1, 32'h0);
		chk(rd, 32'h005FFFFB, "output one scaling");
		apb(1'b0, smc_pkg::OFF_OUT2, 32'h0);
		chk(rd, 32'h00640000, "output two scaling");
		TERM.send_str("223");
		TERM.send_str("5\01530\015");
		apb(1'b0, smc_pkg::OFF_BAL, 32'h0);
		chk(rd, 32'h0000200C, "interval with hour 30 refused");
		TERM.send_str("35\01512\015EE");
		chk_mode(1'b0);
		apb(1'b0, smc_pkg::OFF_BAL, 32'h0);
		chk(rd, 32'h000020AC, "automatic type, 5 days 12 hours");
	endtask

	// Serial units, handshake code, front-panel display options
	task automatic sc_ser_disp();
		TERM.enter_menu();
		TERM.send_str("3164E");
		apb(1'b0, smc_pkg::OFF_SER, 32'h0);
		chk(rd, 32'h00000108, "serial units and output params");
		TERM.send_str("2ACCESX\015");
		apb(1'b0, smc_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h00000002, "handshake kept on wrong code");
		TERM.send_str("2ACCESS\015E");
		apb(1'b0, smc_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h00000003, "handshake toggled");
		TERM.send_str("4F2E23E32E162EEE");
		chk_mode(1'b0);
		apb(1'b0, smc_pkg::OFF_DISP, 32'h0);
		chk({27'h0, rd[4:0]}, 32'h2, "display units");
		chk({31'h0, rd[9]}, 32'h1, "alternate mode");
		chk({30'h0, rd[6:5]}, 32'(smc_pkg::ACC_HIDE), "output access");
		chk({30'h0, rd[8:7]}, 32'(smc_pkg::ACC_CHANGE), "alarm access");
	endtask

	// Reset in mid-run brings every setting back to its default
	task automatic sc_reset();
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		apb(1'b0, smc_pkg::OFF_DISP, 32'h0);
		chk(rd, 32'h0000001F, "display defaults");
		apb(1'b0, smc_pkg::OFF_OUT1, 32'h0);
		chk(rd, 32'h003CFFD8, "output one default");
		apb(1'b0, smc_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h00000000, "handshake default off");
	endtask

	task automatic sc_query();
		TERM.enter_menu();
		TERM.send_str("3QEE");
		chk_mode(1'b0);
		chk({31'h0, periodic_out_en}, 32'h0, "periodic off");
		for (int k = 1; k <= 3; k++) begin
			TERM.send_char(smc_pkg::CH_D);
			TERM.send_char(8'(smc_pkg::CH_0 + k));
			TERM.send_char(smc_pkg::CH_CR);
			repeat (3) @(posedge ref_clk);
			chk(q_cnt, k, "query answers");
			chk({30'h0, q_unit}, 32'(k), "query unit");
		end
		TERM.send_str("d1\015");
		repeat (3) @(posedge ref_clk);
		chk(q_cnt, 3, "lower case query");
	endtask

	// Hang guard
	initial begin
		#5_000_000;
		bad_count++;
		$display("BAD %0t run too long", $time);
		end_sim();
	end

	initial begin
		{psel, penable, pwrite, balance_busy} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		reset = 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		apb(1'b0, smc_pkg::OFF_AVG, 32'h0);
		chk(rd, 32'h14, "avg reset");
		chk({30'h0, periodic_out_en, cooler_enable}, 32'h3, "reset outputs");
		chk({29'h0, display_unit}, 32'h0, "fixed display unit");
		apb(1'b0, smc_pkg::OFF_BAL, 32'h0);
		chk(rd, 32'h0000000C, "balance defaults");
		sc_entry();
		sc_avg();
		sc_balance();
		sc_scale_bal();
		sc_ser_disp();
		sc_query();
		sc_reset();
		end_sim();
	end
endmodule
`default_nettype wire
